// >>> rtl/mcs_defs.vh
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH
// register indices (byte pointer on the serial bus, word index on apb)
`define MCS_REG_STATUS 4'h0
`define MCS_REG_CTRL 4'h1
`define MCS_REG_TRIG 4'h2
`define MCS_REG_HOLE 4'h3
`define MCS_REG_DATA0 4'h4
// control fields
`define MCS_CTRL_RST 8'h00
`define MCS_CTRL_KELVIN 7
`define MCS_CTRL_REPEAT 6
`define MCS_CTRL_TINT_OFF 5
`define MCS_CTRL_VCC_EN 4
`define MCS_PAIR_OFF 2'b00
`define MCS_PAIR_SE 2'b01
`define MCS_PAIR_DIFF 2'b10
`define MCS_PAIR_TEMP 2'b11
// acquisition slots in their fixed order
`define MCS_SLOT_TINT 3'd0
`define MCS_SLOT_V1 3'd1
`define MCS_SLOT_V3 3'd3
`define MCS_SLOT_VCC 3'd5
`define MCS_NSLOT 6
// remote diode conversions per result, last step index
`define MCS_RD_LAST 2'd2
// celsius offset, 273.125 degrees in 1/16 units
`define MCS_KELVIN_OFS 13'h1112
// timing
`define MCS_CONV_TIME_NS 1500000
`define MCS_CLK_PERIOD_NS 25
// serial bus base address, low two bits come from the select pins
`define MCS_I2C_BASE 7'h4c
`endif

// >>> rtl/mcs_conv_timer.v
`timescale 1ns/10ps
`default_nettype none
module mcs_conv_timer #(
   parameter CYC = 60000,
   parameter W = 17
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire start_i,
   output reg done_o
);
   localparam [W-1:0] LAST = CYC[W-1:0] - 1'b1;
   reg [W-1:0] cnt_q;
   reg run_q;

   // a new start restarts the count; sequencer never overlaps them
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_q <= {W{1'b0}};
         run_q <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q == LAST) begin
               run_q <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/mcs_i2c_slave.v
`timescale 1ns/10ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_i2c_slave #(
   parameter [6:0] BASE = `MCS_I2C_BASE
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire scl_i,
   input wire sda_i,
   input wire address_select_low_i,
   input wire address_select_high_i,
   input wire [7:0] rdata_i,
   output reg sda_oe_n_o,
   output reg wr_o,
   output reg rd_o,
   output reg [7:0] addr_o,
   output reg [7:0] wdata_o
);
   localparam ST_IDLE = 6'b000001;
   localparam ST_ADDR = 6'b000010;
   localparam ST_ACK = 6'b000100;
   localparam ST_RX = 6'b001000;
   localparam ST_TX = 6'b010000;
   localparam ST_MACK = 6'b100000;

   reg [1:0] scl_s, sda_s, adr_s0, adr_s1;
   reg scl_p, sda_p, rw_q, first_q;
   reg [5:0] st_q;
   reg [7:0] sh_q;
   reg [3:0] cnt_q;
   wire scl = scl_s[1];
   wire sda = sda_s[1];
   wire rise = scl & ~scl_p;
   wire fall = ~scl & scl_p;
   wire start = scl & scl_p & sda_p & ~sda;
   wire stop = scl & scl_p & ~sda_p & sda;

   always @(posedge ref_clk_i) begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      adr_s0 <= {adr_s0[0], address_select_low_i};
      adr_s1 <= {adr_s1[0], address_select_high_i};
      scl_p <= scl;
      sda_p <= sda;
   end

   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         sda_oe_n_o <= 1'b1;
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         addr_o <= 8'h00;
         wdata_o <= 8'h00;
      end else begin
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         if (start) begin
            st_q <= ST_ADDR;
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            sda_oe_n_o <= 1'b1;
         end else if (stop) begin
            st_q <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  sda_oe_n_o <= 1'b1;
               end
               ST_ADDR: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     if (sh_q[7:1] == {BASE[6:2], adr_s1[1], adr_s0[1]}) begin
                        rw_q <= sh_q[0];
                        sda_oe_n_o <= 1'b0;
                        st_q <= ST_ACK;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_ACK: begin
                  if (fall) begin
                     cnt_q <= 4'h0;
                     if (rw_q) begin
                        // byte fetched at the pointer, pointer advances
                        sh_q <= {rdata_i[6:0], 1'b1};
                        sda_oe_n_o <= rdata_i[7];
                        rd_o <= 1'b1;
                        st_q <= ST_TX;
                     end else begin
                        sda_oe_n_o <= 1'b1;
                        st_q <= ST_RX;
                     end
                  end
               end
               ST_RX: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     first_q <= 1'b0;
                     if (first_q) begin
                        addr_o <= sh_q;
                     end else begin
                        wr_o <= 1'b1;
                        wdata_o <= sh_q;
                     end
                     sda_oe_n_o <= 1'b0;
                     st_q <= ST_ACK;
                  end
               end
               ST_TX: begin
                  if (rise) begin
                     cnt_q <= cnt_q + 4'h1;
                  end else if (fall) begin
                     if (cnt_q == 4'h8) begin
                        sda_oe_n_o <= 1'b1;
                        st_q <= ST_MACK;
                     end else begin
                        sda_oe_n_o <= sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b1};
                     end
                  end
               end
               ST_MACK: begin
                  // master nack ends the read, ack fetches the next byte
                  if (rise) begin
                     st_q <= sda ? ST_IDLE : ST_ACK;
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
            if (rd_o) begin
               addr_o <= addr_o + 8'h01;
            end
            if (wr_o) begin
               addr_o <= addr_o + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/mcs_monitor_sequencer.v
// Overview of operation
// - enabled acquisitions run die temp, inputs one to four, then supply
// - control mode field picks acquisitions and steers the input mux
// - serial slave answers one of four addresses set by two pins
// - supply low holds reset and serial traffic is ignored
// - low supply or power-on reset zeroes data and control registers
// - normal operation starts only once supply rises above threshold
// - serial bus works at standard and fast rates, master stays within
// - trigger register write starts one pass or repeated passes
// - data registers carry a fresh flag, set on update, cleared on read
// - remote temperature biases input one or three of the chosen pair
// - remote diode result combines several conversions at stepped currents
// - current and remote temperature use pairs differentially
// - each conversion takes the nominal 1.5 ms
// - temperature is 13 bits, 9 integer and 4 fraction
// - voltages stored directly, temperatures computed first
// - control bit 7 selects kelvin or celsius for all temperatures
// - repeated mode keeps refreshing results after one trigger
// - status bit set per new result, cleared when its data is addressed
// - default control measures only die temperature on trigger
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_defs.vh"
module mcs_monitor_sequencer #(
   parameter CONV_CYC = `MCS_CONV_TIME_NS / `MCS_CLK_PERIOD_NS,
   parameter [6:0] I2C_BASE = `MCS_I2C_BASE
) (
   input wire ref_clk_i,
   input wire srst_i,
   input wire supply_low_detect_i,
   input wire [7:0] paddr_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire scl_i,
   input wire sda_i,
   output wire sda_oe_n_o,
   input wire address_select_low_i,
   input wire address_select_high_i,
   input wire [13:0] adc_data_i,
   output reg adc_start_o,
   output reg [2:0] mux_sel_o,
   output reg mux_diff_o,
   output reg [1:0] bias_en_o,
   output reg [1:0] bias_level_o,
   output reg busy_o
);
   localparam SQ_IDLE = 3'b001;
   localparam SQ_NEXT = 3'b010;
   localparam SQ_CONV = 3'b100;
   localparam N = `MCS_NSLOT;

   reg [1:0] uv_s;
   reg [7:0] ctrl_q;
   reg [13:0] res_q [0:N-1];
   reg [N-1:0] fresh_q, tflag_q;
   reg [2:0] sq_q, slot_q;
   reg [1:0] step_q;
   reg [13:0] acc_q;
   wire conv_done;
   wire i2c_wr, i2c_rd;
   wire [7:0] i2c_addr, i2c_wdata;

   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         uv_s <= 2'b00;
      end else begin
         uv_s <= {uv_s[0], supply_low_detect_i};
      end
   end
   // released only once supply is good
   wire rst = srst_i | uv_s[1];

   function [2:0] slot_of;
      input [3:0] a;
      begin
         slot_of = a[3:1] - 3'd2;
      end
   endfunction

   function [1:0] pair_of;
      input [2:0] s;
      input [7:0] c;
      begin
         pair_of = (s >= `MCS_SLOT_V3) ? c[3:2] : c[1:0];
      end
   endfunction

   function slot_en;
      input [2:0] s;
      input [7:0] c;
      begin
         case (s)
            3'd0: slot_en = ~c[`MCS_CTRL_TINT_OFF];
            3'd1, 3'd3: slot_en = pair_of(s, c) != `MCS_PAIR_OFF;
            3'd2, 3'd4: slot_en = pair_of(s, c) == `MCS_PAIR_SE;
            3'd5: slot_en = c[`MCS_CTRL_VCC_EN];
            default: slot_en = 1'b0;
         endcase
      end
   endfunction

   function [7:0] reg_rd;
      input [3:0] a;
      reg [2:0] s;
      begin
         s = slot_of(a);
         if (a == `MCS_REG_STATUS) begin
            reg_rd = {1'b0, fresh_q, busy_o};
         end else if (a == `MCS_REG_CTRL) begin
            reg_rd = ctrl_q;
         end else if (a < `MCS_REG_DATA0) begin
            reg_rd = 8'h00;
         end else if (a[0]) begin
            reg_rd = res_q[s][7:0];
         end else if (tflag_q[s]) begin
            reg_rd = {fresh_q[s], 2'b00, res_q[s][12:8]};
         end else begin
            reg_rd = {fresh_q[s], 1'b0, res_q[s][13:8]};
         end
      end
   endfunction

   // apb slave, zero wait states
   wire apb_setup = psel_i & ~penable_i;
   wire apb_done = psel_i & penable_i & pready_o;
   wire [3:0] apb_idx = paddr_i[5:2];
   wire apb_bad = (|paddr_i[7:6]) | (|paddr_i[1:0]) | (apb_idx == `MCS_REG_HOLE);
   wire apb_ok = apb_done & ~apb_bad;
   wire i2c_in = i2c_addr[7:4] == 4'h0;
   wire [7:0] i2c_rdata = i2c_in ? reg_rd(i2c_addr[3:0]) : 8'h00;

   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= apb_setup;
         pslverr_o <= apb_setup & apb_bad;
         if (apb_setup) begin
            prdata_o <= apb_bad ? 32'h00000000 : {24'h000000, reg_rd(apb_idx)};
         end
      end
   end

   // apb write wins a collision with a serial write
   wire apb_wr = apb_ok & pwrite_i;
   wire wr_en = apb_wr | (i2c_wr & i2c_in);
   wire [3:0] wr_idx = apb_wr ? apb_idx : i2c_addr[3:0];
   wire [7:0] wr_dat = apb_wr ? pwdata_i[7:0] : i2c_wdata;
   wire trig = wr_en & (wr_idx == `MCS_REG_TRIG);
   wire apb_rd = apb_ok & ~pwrite_i & (apb_idx >= `MCS_REG_DATA0);
   wire ser_rd = i2c_rd & i2c_in & (i2c_addr[3:0] >= `MCS_REG_DATA0);

   // sequencer decode of the current slot
   wire [1:0] pair = pair_of(slot_q, ctrl_q);
   wire pslot = (slot_q == `MCS_SLOT_V1) | (slot_q == `MCS_SLOT_V3);
   wire rem = pslot & (pair == `MCS_PAIR_TEMP);
   wire diff = pslot & (pair != `MCS_PAIR_SE);
   wire tslot = (slot_q == `MCS_SLOT_TINT) | rem;
   wire store = (sq_q == SQ_CONV) & conv_done & ~(rem & (step_q != `MCS_RD_LAST));
   // kelvin from three stepped-current samples, 2*s1 - s0 - s2
   wire [12:0] kel = rem ? (acc_q[12:0] - adc_data_i[12:0]) : adc_data_i[12:0];
   wire [12:0] tval = ctrl_q[`MCS_CTRL_KELVIN] ? kel : kel - `MCS_KELVIN_OFS;
   wire [13:0] rval = tslot ? {1'b0, tval} : adc_data_i;
   wire last = slot_q == `MCS_SLOT_VCC;

   // fresh flags, set wins over read clear
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_fresh
         wire set = store & (slot_q == g);
         wire clr = (apb_rd & (slot_of(apb_idx) == g)) |
            (ser_rd & (slot_of(i2c_addr[3:0]) == g));
         always @(posedge ref_clk_i) begin
            if (rst) begin
               fresh_q[g] <= 1'b0;
               tflag_q[g] <= 1'b0;
               res_q[g] <= 14'h0000;
            end else begin
               fresh_q[g] <= set | (fresh_q[g] & ~clr);
               if (set) begin
                  tflag_q[g] <= tslot;
                  res_q[g] <= rval;
               end
            end
         end
      end
   endgenerate

   always @(posedge ref_clk_i) begin
      // zero control means die temperature only
      if (rst) begin
         ctrl_q <= `MCS_CTRL_RST;
      end else if (wr_en && wr_idx == `MCS_REG_CTRL) begin
         ctrl_q <= wr_dat;
      end
   end

   always @(posedge ref_clk_i) begin
      if (rst) begin
         sq_q <= SQ_IDLE;
         slot_q <= 3'd0;
         step_q <= 2'd0;
         acc_q <= 14'h0000;
         busy_o <= 1'b0;
         adc_start_o <= 1'b0;
         mux_sel_o <= 3'd0;
         mux_diff_o <= 1'b0;
         bias_en_o <= 2'b00;
         bias_level_o <= 2'b00;
      end else begin
         adc_start_o <= 1'b0;
         case (sq_q)
            SQ_IDLE: begin
               // triggers while a pass runs are dropped
               if (trig) begin
                  busy_o <= 1'b1;
                  slot_q <= 3'd0;
                  sq_q <= SQ_NEXT;
               end
            end
            SQ_NEXT: begin
               if (slot_en(slot_q, ctrl_q)) begin
                  adc_start_o <= 1'b1;
                  mux_sel_o <= slot_q;
                  mux_diff_o <= diff;
                  // bias on the positive input of the pair
                  bias_en_o <= rem ? ((slot_q == `MCS_SLOT_V1) ? 2'b01 : 2'b10) : 2'b00;
                  bias_level_o <= 2'b00;
                  step_q <= 2'd0;
                  acc_q <= 14'h0000;
                  sq_q <= SQ_CONV;
               end else if (!last) begin
                  slot_q <= slot_q + 3'd1;
               // keep going without a new trigger
               end else if (ctrl_q[`MCS_CTRL_REPEAT]) begin
                  slot_q <= 3'd0;
               end else begin
                  busy_o <= 1'b0;
                  sq_q <= SQ_IDLE;
               end
            end
            SQ_CONV: begin
               // wait out the nominal conversion time
               if (conv_done) begin
                  if (rem && step_q != `MCS_RD_LAST) begin
                     acc_q <= (step_q == 2'd0) ? (14'h0000 - adc_data_i) :
                        (acc_q + {adc_data_i[12:0], 1'b0});
                     step_q <= step_q + 2'd1;
                     bias_level_o <= step_q + 2'd1;
                     adc_start_o <= 1'b1;
                  end else begin
                     bias_en_o <= 2'b00;
                     mux_diff_o <= 1'b0;
                     sq_q <= SQ_NEXT;
                     if (!last) begin
                        slot_q <= slot_q + 3'd1;
                     end else if (ctrl_q[`MCS_CTRL_REPEAT]) begin
                        slot_q <= 3'd0;
                     end else begin
                        busy_o <= 1'b0;
                        sq_q <= SQ_IDLE;
                     end
                  end
               end
            end
            default: begin
               sq_q <= SQ_IDLE;
            end
         endcase
      end
   end

   mcs_conv_timer #(
      .CYC(CONV_CYC),
      .W(20)
   ) u_timer (
      .ref_clk_i(ref_clk_i),
      .srst_i(rst),
      .start_i(adc_start_o),
      .done_o(conv_done)
   );

   // oversampled at 40 MHz, fine up to fast-mode rate
   // slave held in reset while supply is low
   mcs_i2c_slave #(
      .BASE(I2C_BASE)
   ) u_i2c (
      .ref_clk_i(ref_clk_i),
      .srst_i(rst),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .address_select_low_i(address_select_low_i),
      .address_select_high_i(address_select_high_i),
      .rdata_i(i2c_rdata),
      .sda_oe_n_o(sda_oe_n_o),
      .wr_o(i2c_wr),
      .rd_o(i2c_rd),
      .addr_o(i2c_addr),
      .wdata_o(i2c_wdata)
   );
endmodule
`default_nettype wire

// >>> verif/mcs_monitor_sequencer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mcs_monitor_sequencer_chk #(
   parameter int CONV_CYC = 20
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic supply_low_detect_i,
   input wire logic sda_oe_n_o,
   input wire logic adc_start_o,
   input wire logic [2:0] mux_sel_o,
   input wire logic mux_diff_o,
   input wire logic [1:0] bias_en_o,
   input wire logic [1:0] bias_level_o,
   input wire logic busy_o
);
   int gap_q;
   logic seen_q;
   logic [1:0] lvl_q;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // cycles since last start; any reset restarts the count
   always @(posedge ref_clk_i) begin
      if (srst_i || supply_low_detect_i) begin
         seen_q <= 1'b0;
         gap_q <= 0;
         lvl_q <= 2'd0;
      end else if (adc_start_o) begin
         seen_q <= 1'b1;
         gap_q <= 0;
         lvl_q <= bias_level_o;
      end else if (gap_q < 100000) begin
         gap_q <= gap_q + 1;
      end
   end
   property p_start_pulse; adc_start_o |=> !adc_start_o; endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("conversion start wider than one cycle");
   property p_conv_gap; adc_start_o && seen_q |-> gap_q >= CONV_CYC; endproperty
   a_conv_gap: assert property (p_conv_gap)
      else $error("conversion cut short");
   property p_start_busy; adc_start_o |-> busy_o; endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("conversion started while idle");
   property p_busy_start; $rose(busy_o) |-> ##[0:8] adc_start_o; endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("pass began without a conversion");
   property p_supply_quiet;
      supply_low_detect_i [*4] |-> sda_oe_n_o && !busy_o && !adc_start_o && bias_en_o == 2'b00;
   endproperty
   a_supply_quiet: assert property (p_supply_quiet)
      else $error("activity during low supply");
   property p_bias_pair;
      bias_en_o != 2'b00 |-> mux_diff_o && (bias_en_o == 2'b01 ? mux_sel_o == 3'd1 :
         bias_en_o == 2'b10 && mux_sel_o == 3'd3);
   endproperty
   a_bias_pair: assert property (p_bias_pair)
      else $error("bias source on wrong input");
   property p_diff_sel; mux_diff_o |-> mux_sel_o == 3'd1 || mux_sel_o == 3'd3; endproperty
   a_diff_sel: assert property (p_diff_sel)
      else $error("differential mode on a single input");
   property p_bias_step; bias_en_o != 2'b00 |-> bias_level_o <= 2'd2; endproperty
   a_bias_step: assert property (p_bias_step)
      else $error("bias step out of range");
   property p_step_order;
      adc_start_o && bias_en_o != 2'b00 && bias_level_o != 2'd0 |-> bias_level_o == lvl_q + 2'd1;
   endproperty
   a_step_order: assert property (p_step_order)
      else $error("bias steps out of order");
endmodule
bind mcs_monitor_sequencer mcs_monitor_sequencer_chk #(.CONV_CYC(CONV_CYC)) u_chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .supply_low_detect_i(supply_low_detect_i),
   .sda_oe_n_o(sda_oe_n_o), .adc_start_o(adc_start_o), .mux_sel_o(mux_sel_o),
   .mux_diff_o(mux_diff_o), .bias_en_o(bias_en_o), .bias_level_o(bias_level_o),
   .busy_o(busy_o));
`default_nettype wire

// >>> verif/mcs_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
module mcs_i2c_master (
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // bus idles released, pulled high
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic bit_out(input logic v);
      sda_o <= v;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      scl_o <= 1'b0;
      wt(2);
   endtask
   // longer low phases give the slave time to drive and release
   task automatic ack_in(output logic a);
      sda_o <= 1'b1;
      wt(4);
      scl_o <= 1'b1;
      wt(2);
      a = !sda_i;
      wt(2);
      scl_o <= 1'b0;
      wt(6);
   endtask
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d, output logic ack);
      logic a;
      logic [7:0] b [3];
      b = '{{dev, 1'b0}, ptr, d};
      ack = 1'b1;
      sda_o <= 1'b0;
      wt(4);
      scl_o <= 1'b0;
      wt(2);
      for (int k = 0; k < 3; k++) begin
         for (int i = 7; i >= 0; i--) bit_out(b[k][i]);
         ack_in(a);
         ack = ack & a;
      end
      sda_o <= 1'b0;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      sda_o <= 1'b1;
      wt(8);
   endtask
   // one byte read at the pointer, then nack
   task automatic read_reg(input logic [6:0] dev, output logic [7:0] q);
      logic a;
      logic [7:0] b;
      b = {dev, 1'b1};
      sda_o <= 1'b0;
      wt(4);
      scl_o <= 1'b0;
      wt(2);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      ack_in(a);
      for (int i = 7; i >= 0; i--) begin
         ack_in(a);
         q[i] = !a;
      end
      bit_out(1'b1);
      sda_o <= 1'b0;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      sda_o <= 1'b1;
      wt(8);
   endtask
endmodule
`default_nettype wire

// >>> verif/mcs_monitor_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module mcs_monitor_sequencer_test;
   localparam int CONV = 20;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply_low_detect_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [1:0] asel = 2'b00;
   logic [13:0] adc_data_i = 14'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, scl, m_sda, sda_oe_n_o, sda_line, adc_start_o, mux_diff_o, busy_o;
   logic [2:0] mux_sel_o;
   logic [1:0] bias_en_o, bias_level_o;
   logic [2:0] sels [$];
   int num_errors = 0;
   int checks_done = 0;
   assign sda_line = m_sda & sda_oe_n_o;
   always #12.5 ref_clk_i = ~ref_clk_i;
   // adc value marks slot; middle bias step reads higher
   always @(posedge ref_clk_i) begin
      if (adc_start_o === 1'b1) sels.push_back(mux_sel_o);
      adc_data_i <= 14'h1200 + {8'h00, mux_sel_o, 3'h0} + (bias_level_o == 2'd1 ? 14'h0100 : 14'h0);
   end
   mcs_monitor_sequencer #(.CONV_CYC(CONV)) u_mcs_monitor_sequencer (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .supply_low_detect_i(supply_low_detect_i),
      .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .scl_i(scl), .sda_i(sda_line), .sda_oe_n_o(sda_oe_n_o), .address_select_low_i(asel[0]),
      .address_select_high_i(asel[1]), .adc_data_i(adc_data_i), .adc_start_o(adc_start_o),
      .mux_sel_o(mux_sel_o), .mux_diff_o(mux_diff_o), .bias_en_o(bias_en_o),
      .bias_level_o(bias_level_o), .busy_o(busy_o));
   mcs_i2c_master u_mcs_i2c_master (.ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl),
      .sda_o(m_sda));
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         num_errors++;
         finish_test();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      logic x;
      apb(1'b0, a, 8'h00, r, x);
      `CHK(nm, {24'h0, e}, r)
   endtask
   task automatic dchk(input int s, input logic [7:0] m, input logic [7:0] l);
      rc("data msb", 8'(16 + 8 * s), m);
      rc("data lsb", 8'(20 + 8 * s), l);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge ref_clk_i);
      while (busy_o !== 1'b0 && n < 3000) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (n >= 3000) begin
         num_errors++;
         finish_test();
      end
   endtask
   task automatic pass(input logic [7:0] c, input logic [2:0] ex [$]);
      wr(8'h04, c);
      sels.delete();
      wr(8'h08, 8'h01);
      wait_idle();
      `CHK("slot count", ex.size(), sels.size())
      foreach (ex[i]) `CHK("slot", ex[i], sels[i])
   endtask
   initial begin
      logic [31:0] r;
      logic e, ack;
      logic [7:0] q;
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      rc("ctrl reset", 8'h04, 8'h00);
      rc("die reset", 8'h10, 8'h00);
      apb(1'b0, 8'h0c, 8'h00, r, e);
      `CHK("hole error", 1'b1, e)
      wr(8'h00, 8'hff);
      rc("status", 8'h00, 8'h00);
      pass(8'h00, '{3'd0});
      rc("status die", 8'h00, 8'h02);
      dchk(0, 8'h80, 8'hee);
      rc("die reread", 8'h10, 8'h00);
      rc("status clear", 8'h00, 8'h00);
      pass(8'h95, '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5});
      rc("status all", 8'h00, 8'h7e);
      dchk(0, 8'h92, 8'h00);
      for (int s = 1; s < 6; s++) dchk(s, 8'h92, 8'(8 * s));
      pass(8'h38, '{3'd3, 3'd5});
      dchk(3, 8'h92, 8'h18);
      dchk(5, 8'h92, 8'h28);
      pass(8'ha3, '{3'd1, 3'd1, 3'd1});
      dchk(1, 8'h82, 8'h00);
      pass(8'h2c, '{3'd3, 3'd3, 3'd3});
      dchk(3, 8'h90, 8'hee);
      wr(8'h04, 8'h40);
      sels.delete();
      wr(8'h08, 8'h01);
      repeat (4 * (CONV + 10)) @(posedge ref_clk_i);
      `CHK("repeat count", 1'b1, sels.size() >= 3)
      `CHK("wrap slot", 3'd0, sels[1])
      wr(8'h04, 8'h00);
      wait_idle();
      rc("status repeat", 8'h00, 8'h02);
      for (int s = 0; s < 4; s++) begin
         asel <= 2'(s);
         repeat (4) @(posedge ref_clk_i);
         u_mcs_i2c_master.write_reg(7'h4c | 7'(s), 8'h01, 8'(16 + s), ack);
         `CHK("ack own", 1'b1, ack)
         u_mcs_i2c_master.write_reg(7'h4c | 7'(s ^ 1), 8'h01, 8'h00, ack);
         `CHK("ack other", 1'b0, ack)
         rc("ctrl serial", 8'h04, 8'(16 + s));
      end
      u_mcs_i2c_master.write_reg(7'h4f, 8'h03, 8'h00, ack);
      u_mcs_i2c_master.read_reg(7'h4f, q);
      `CHK("serial read", 8'h80, q)
      rc("status serial", 8'h00, 8'h00);
      wr(8'h04, 8'h40);
      wr(8'h08, 8'h01);
      supply_low_detect_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      u_mcs_i2c_master.write_reg(7'h4f, 8'h01, 8'h33, ack);
      `CHK("ack low supply", 1'b0, ack)
      supply_low_detect_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rc("ctrl after", 8'h04, 8'h00);
      rc("die after", 8'h10, 8'h00);
      pass(8'h00, '{3'd0});
      finish_test();
   end
endmodule
`default_nettype wire
